/* File: vref_bias_ctrl.sv */
`timescale 1ns/1ps
// Operation
// (R1) Bit 3 selects reference: 0 external pin, 1 supply voltage.
// (R2) Writing 1 to bit 1 enables ADC bias generator unconditionally.
// (R3) ADC bias enable forced high while ADC or oscillator is enabled.
// (R4) Reference bias enabled by internal reference, temp sensor or multiplier.
// (R5) Bit 2 turns temp sensor on; 0 holds it off, output high-impedance.
// (R6) Bit 0 enables reference buffer driving internal reference onto pin.
// (R7) Upper bits 7..4 read zero and ignore writes.
// (R8) Software should make reference pin analog input and crossbar skip it.
// (R9) Stored bits update on write edge; bias outputs follow from stored bits.
module vref_bias_ctrl
   import vref_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Peripheral enables, same clock domain
   input wire logic adc_enable,
   input wire logic int_osc_enable,
   input wire logic clock_mult_enable,
   // Analog controls
   output logic reference_source_select,
   output logic temp_sensor_enable,
   output logic reference_buffer_enable,
   output logic adc_bias_enable,
   output logic reference_bias_enable
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [7:0] ctrl_reg;
   wire logic [7:0] ctrl_next;
   logic [7:0] rdata_next;
   logic hit;
   logic wr_hit;
   logic rd_hit;
   logic adc_bias_next;
   logic ref_bias_next;
   assign hit = (sfr_addr == REFERENCE_CONTROL_ADDR);
   assign wr_hit = hit && sfr_wr;
   assign rd_hit = hit && sfr_rd;
   // ------------------------------------------------------------
   // Field storage, one slice per register bit
   // ------------------------------------------------------------
   // Upper bits are never stored, so they cannot leak back on reads
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_field
         if (REFERENCE_CONTROL_USED_MASK[gi]) begin : g_used
            assign ctrl_next[gi] = wr_hit ? sfr_wdata[gi] : ctrl_reg[gi]; // (R7) (R9)
         end else begin : g_unused
            assign ctrl_next[gi] = 1'b0; // (R7)
         end
      end
   endgenerate
   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Read during write returns the value being written
   assign rdata_next = rd_hit ? (ctrl_next & REFERENCE_CONTROL_USED_MASK) : 8'h00; // (R7)
   // Combine with peripheral requests; computed from next state so outputs stay flopped
   assign adc_bias_next = ctrl_next[ADC_BIAS_ENABLE_BIT] | adc_enable | int_osc_enable; // (R2) (R3)
   // The internal reference is in use whenever its buffer is on
   assign ref_bias_next = ctrl_next[REFERENCE_BUFFER_ENABLE_BIT]
                        | ctrl_next[TEMP_SENSOR_ENABLE_BIT] | clock_mult_enable; // (R4)
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Control register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= REFERENCE_CONTROL_RESET;
      end else if (clk_en) begin
         ctrl_reg <= ctrl_next; // (R9)
      end
   end
   // ------------------------------------------------------------
   // Bias outputs
   // ------------------------------------------------------------
   // One cycle behind their causes, traded for outputs straight from flops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_bias_enable <= 1'b0;
      end else if (clk_en) begin
         adc_bias_enable <= adc_bias_next; // (R3)
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reference_bias_enable <= 1'b0;
      end else if (clk_en) begin
         reference_bias_enable <= ref_bias_next; // (R4)
      end
   end
   // ------------------------------------------------------------
   // Read data register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en) begin
         sfr_rdata <= rdata_next; // (R7)
      end
   end
   // Fields map straight from the stored register
   assign reference_source_select = ctrl_reg[REFERENCE_SOURCE_SELECT_BIT]; // (R1)
   assign temp_sensor_enable = ctrl_reg[TEMP_SENSOR_ENABLE_BIT]; // (R5)
   assign reference_buffer_enable = ctrl_reg[REFERENCE_BUFFER_ENABLE_BIT]; // (R6)
   // Tristating the sensor output is done in the analog cell from this enable
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_write(logic [7:0] d);
      clk_en && hit && sfr_wr && sfr_wdata == d;
   endsequence
   a_source_select: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R1)
      clk_en && hit && sfr_wr |=> reference_source_select == $past(sfr_wdata[3]))
      else $error("reference select not taken from write");
   a_bias_manual: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R2)
      clk_en && hit && sfr_wr && sfr_wdata[1] |=> adc_bias_enable)
      else $error("manual bias enable ignored");
   a_bias_forced: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R3)
      clk_en && (adc_enable || int_osc_enable) |=> adc_bias_enable)
      else $error("bias not forced by peripheral");
   a_refbias_auto: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R4)
      clk_en && clock_mult_enable |=> reference_bias_enable)
      else $error("reference bias not enabled by multiplier");
   a_refbias_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R4)
      clk_en ##1 (reference_bias_enable && !temp_sensor_enable && !reference_buffer_enable)
      |-> $past(clock_mult_enable))
      else $error("reference bias set without cause");
   a_temp_enable: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R5)
      clk_en && hit && sfr_wr |=> temp_sensor_enable == $past(sfr_wdata[2]))
      else $error("temp sensor enable mismatch");
   a_buffer_enable: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R6)
      s_write(8'h01) |=> reference_buffer_enable && !temp_sensor_enable)
      else $error("buffer enable mismatch");
   a_upper_zero: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R7)
      sfr_rdata[7:4] == 4'h0 && ctrl_reg[7:4] == 4'h0)
      else $error("upper bits not zero");
   a_hold_value: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R9)
      !(hit && sfr_wr) |=> $stable(ctrl_reg))
      else $error("register changed without write");
   // ------------------------------------------------------------
   // Assertions: field outputs
   // ------------------------------------------------------------
   a_supply_only: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R1)
      s_write(8'h08) |=> reference_source_select == SOURCE_SUPPLY
         && !temp_sensor_enable && !reference_buffer_enable)
      else $error("supply select write mismatch");
   a_source_ext: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R1)
      clk_en && wr_hit && !sfr_wdata[REFERENCE_SOURCE_SELECT_BIT]
      |=> reference_source_select == SOURCE_EXTERNAL_PIN)
      else $error("external pin select mismatch");
   a_sensor_on: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R5)
      clk_en && wr_hit && sfr_wdata[TEMP_SENSOR_ENABLE_BIT] |=> temp_sensor_enable)
      else $error("temp sensor not turned on");
   a_buffer_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R6)
      clk_en && wr_hit && !sfr_wdata[REFERENCE_BUFFER_ENABLE_BIT] |=> !reference_buffer_enable)
      else $error("buffer not turned off");
   // ------------------------------------------------------------
   // Assertions: bias generators
   // ------------------------------------------------------------
   sequence s_bias_idle;
      clk_en && !wr_hit && !ctrl_reg[ADC_BIAS_ENABLE_BIT] && !adc_enable && !int_osc_enable;
   endsequence
   a_bias_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R3)
      s_bias_idle |=> !adc_bias_enable)
      else $error("bias on without cause");
   a_bias_stored: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R2)
      clk_en && !wr_hit && ctrl_reg[ADC_BIAS_ENABLE_BIT] |=> adc_bias_enable)
      else $error("stored bias enable not held");
   a_bias_osc: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R3)
      clk_en && int_osc_enable && !adc_enable |=> adc_bias_enable)
      else $error("bias not forced by oscillator");
   a_refbias_buffer: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R4)
      clk_en && wr_hit && sfr_wdata[REFERENCE_BUFFER_ENABLE_BIT] |=> reference_bias_enable)
      else $error("reference bias not enabled by buffer");
   a_refbias_sensor: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R4)
      clk_en && wr_hit && sfr_wdata[TEMP_SENSOR_ENABLE_BIT] |=> reference_bias_enable)
      else $error("reference bias not enabled by sensor");
   a_refbias_held: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R4)
      clk_en && !wr_hit
      && (ctrl_reg[REFERENCE_BUFFER_ENABLE_BIT] || ctrl_reg[TEMP_SENSOR_ENABLE_BIT])
      |=> reference_bias_enable)
      else $error("reference bias dropped while in use");
   // ------------------------------------------------------------
   // Assertions: read port
   // ------------------------------------------------------------
   sequence s_reg_read;
      clk_en && rd_hit && !sfr_wr;
   endsequence
   sequence s_read_write;
      clk_en && rd_hit && wr_hit;
   endsequence
   a_read_fields: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R7)
      s_reg_read |=> sfr_rdata[3] == reference_source_select
         && sfr_rdata[2] == temp_sensor_enable && sfr_rdata[0] == reference_buffer_enable)
      else $error("read data does not match fields");
   a_read_stored: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R9)
      s_reg_read |=> sfr_rdata == ($past(ctrl_reg) & REFERENCE_CONTROL_USED_MASK))
      else $error("read data does not match register");
   a_read_new: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R9)
      s_read_write |=> sfr_rdata == ($past(sfr_wdata) & REFERENCE_CONTROL_USED_MASK))
      else $error("read during write not new value");
   a_read_idle: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R7)
      clk_en && !rd_hit |=> sfr_rdata == 8'h00)
      else $error("read data not zero when idle");
   // ------------------------------------------------------------
   // Assertions: clock enable and reset
   // ------------------------------------------------------------
   sequence s_frozen;
      !clk_en;
   endsequence
   sequence s_reset_held;
      !arst_n ##1 !arst_n;
   endsequence
   a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R9)
      s_frozen |=> $stable(ctrl_reg) && $stable(sfr_rdata)
         && $stable(adc_bias_enable) && $stable(reference_bias_enable))
      else $error("state moved while clock enable low");
   a_freeze_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // (R9)
      !clk_en && wr_hit |=> $stable(reference_source_select)
         && $stable(temp_sensor_enable) && $stable(reference_buffer_enable))
      else $error("write taken while clock enable low");
   a_reset_clear: assert property (@(posedge ref_clk) // (R9)
      s_reset_held |-> ctrl_reg == REFERENCE_CONTROL_RESET && sfr_rdata == 8'h00
         && !adc_bias_enable && !reference_bias_enable)
      else $error("state not cleared in reset");
endmodule

/* File: vref_pkg.sv */
package vref_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hD1;
   localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int REFERENCE_BUFFER_ENABLE_BIT = 0;
   localparam int ADC_BIAS_ENABLE_BIT = 1;
   localparam int TEMP_SENSOR_ENABLE_BIT = 2;
   localparam int REFERENCE_SOURCE_SELECT_BIT = 3;
   localparam logic [7:0] REFERENCE_CONTROL_USED_MASK = 8'h0F;
   // ------------------------------------------------------------
   // Reference source encodings
   // ------------------------------------------------------------
   localparam logic SOURCE_EXTERNAL_PIN = 1'b0;
   localparam logic SOURCE_SUPPLY = 1'b1;
endpackage

/* File: vref_analog_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// Analog sensor stand-in
// ------------------------------------------------
module vref_analog_model (
   // Control from the block
   input wire logic temp_sensor_enable,
   // Sensor output state
   output logic sensor_hiz
);
   assign sensor_hiz = !temp_sensor_enable;
endmodule

/* File: tb_voltage_reference_bias_control.sv */
`timescale 1ns/1ps
module tb_voltage_reference_bias_control;
   import vref_pkg::*;
   logic ref_clk = 0, arst_n = 0, en = 1, wr = 0, rd = 0, adc = 0, osc = 0, mul = 0, hiz;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
   logic src, temp, bufe, abias, rbias;
   int miscompares = 0, total_checks = 0;
   always #5 ref_clk = ~ref_clk;
   vref_bias_ctrl u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(en), .sfr_addr(addr),
      .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .adc_enable(adc),
      .int_osc_enable(osc), .clock_mult_enable(mul), .reference_source_select(src),
      .temp_sensor_enable(temp), .reference_buffer_enable(bufe), .adc_bias_enable(abias),
      .reference_bias_enable(rbias));
   vref_analog_model u_model (.temp_sensor_enable(temp), .sensor_hiz(hiz));
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle();
      @(posedge ref_clk);
      #1;
   endtask
   // Read data stands one cycle only, so it is sampled right after the taking edge
   task automatic cyc(logic w, logic r, logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wd <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic periph(logic a, logic o, logic m);
      @(posedge ref_clk);
      adc <= a;
      osc <= o;
      mul <= m;
      settle();
      settle();
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_fields();
      cyc(0, 1, REFERENCE_CONTROL_ADDR, 8'h00);
      check("reset value", rdata, REFERENCE_CONTROL_RESET);
      cyc(1, 0, REFERENCE_CONTROL_ADDR, 8'hF2);
      settle();
      check("fields", {4'h0, src, temp, abias, bufe}, 8'h02);
      check("no ref bias", {7'h00, rbias}, 8'h00);
      cyc(1, 1, REFERENCE_CONTROL_ADDR, 8'hFD);
      check("upper bits", rdata, 8'h0D);
      settle();
      check("fields", {3'h0, src, temp, abias, bufe, hiz}, 8'h1A);
      cyc(0, 1, 8'hD0, 8'h00);
      check("unmapped", rdata, 8'h00);
      $display("test fields done");
   endtask
   task automatic t_bias();
      cyc(1, 0, REFERENCE_CONTROL_ADDR, 8'h08);
      settle();
      check("idle bias", {6'h00, abias, rbias}, 8'h00);
      periph(1, 0, 0);
      check("adc forces", {6'h00, abias, rbias}, 8'h02);
      periph(0, 1, 0);
      check("osc forces", {6'h00, abias, rbias}, 8'h02);
      periph(0, 0, 1);
      check("mult bias", {6'h00, abias, rbias}, 8'h01);
      periph(0, 0, 0);
      cyc(1, 0, REFERENCE_CONTROL_ADDR, 8'h04);
      settle();
      check("sensor bias", {6'h00, temp, rbias}, 8'h03);
      $display("test bias done");
   endtask
   task automatic t_buffer();
      // External reference with buffer on; pin set-up is left to software
      cyc(1, 0, REFERENCE_CONTROL_ADDR, 8'h01);
      check("buffer only", {4'h0, src, temp, bufe, hiz}, 8'h03);
      check("buffer bias", {6'h00, abias, rbias}, 8'h01);
      cyc(1, 0, 8'hD2, 8'h0F);
      check("unmapped write", {4'h0, src, temp, abias, bufe}, 8'h01);
      @(posedge ref_clk);
      en <= 1'b0;
      cyc(1, 1, REFERENCE_CONTROL_ADDR, 8'h0E);
      check("frozen fields", {4'h0, src, temp, abias, bufe}, 8'h01);
      check("frozen read", rdata, 8'h00);
      @(posedge ref_clk);
      en <= 1'b1;
      cyc(0, 1, REFERENCE_CONTROL_ADDR, 8'h00);
      check("thawed read", rdata, 8'h01);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      settle();
      check("reset outputs", {3'h0, src, temp, abias, bufe, rbias}, 8'h00);
      check("reset hiz", {7'h00, hiz}, 8'h01);
      @(posedge ref_clk);
      arst_n <= 1'b1;
      cyc(0, 1, REFERENCE_CONTROL_ADDR, 8'h00);
      check("reset read", rdata, REFERENCE_CONTROL_RESET);
      $display("test buffer freeze reset done");
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_fields();
      t_bias();
      t_buffer();
      wrap_up();
   end
endmodule
